// ===== verilog/ahl_regs.sv
// lamp, header-check and event counter register bank on the utility bus
`timescale 1ns/1ns
`default_nettype none
module ahl_regs #(
   parameter int LAMP_HOLD_CYC = ahl_pkg::LAMP_HOLD_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ub_cs,
   input wire logic ub_rd,
   input wire logic ub_wr,
   input wire logic [7:0] ub_addr,
   input wire logic [7:0] ub_data_in,
   output logic [7:0] ub_data_out,
   output logic ub_data_oe_n,
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   input wire logic rx_soc,
   input wire logic sym_err,
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_valid_in,
   input wire logic tx_soc_in,
   output logic [7:0] tx_byte_out,
   output logic tx_valid_out,
   output logic tx_soc_out,
   input wire logic tx_queue_empty,
   output logic rx_cell_ref_pulse,
   output logic rx_activity_lamp,
   output logic tx_activity_lamp
);
   localparam int LAMP_W = $clog2(LAMP_HOLD_CYC + 1);

   // bus strobes are level; actions fire once on the leading edge
   logic rd_prev_ff, wr_prev_ff, rd_start, wr_start;
   logic [7:0] rdata_ff, nxt_rdata;
   logic oe_n_ff, nxt_oe_n;
   // control and status
   logic rx_dis_ff, nxt_rx_dis, tx_dis_ff, nxt_tx_dis, ins_ff, nxt_ins;
   logic [1:0] ref_sel_ff, nxt_ref_sel;
   logic [3:0] sel_ff, nxt_sel;
   logic rx_act_ff, nxt_rx_act, tx_act_ff, nxt_tx_act, int_hec_ff, nxt_int_hec;
   logic [ahl_pkg::CNT_W-1:0] cnt_ff [ahl_pkg::NUM_CNT];
   logic [ahl_pkg::CNT_W-1:0] nxt_cnt [ahl_pkg::NUM_CNT];
   logic [ahl_pkg::NUM_CNT-1:0] events;
   logic [ahl_pkg::CNT_W-1:0] sel_val;
   // cell path
   logic rx_is_hec, rx_done, tx_is_hec, tx_done, hec_err;
   logic [7:0] rx_hec, tx_hec;
   logic [7:0] txb_ff, nxt_txb;
   logic txv_ff, nxt_txv, txs_ff, nxt_txs;
   logic [2:0] ref_cnt_ff, nxt_ref_cnt;
   logic ref_ff, nxt_ref;
   logic [LAMP_W-1:0] rx_lamp_cnt_ff, nxt_rx_lamp_cnt, tx_lamp_cnt_ff, nxt_tx_lamp_cnt;
   logic rx_lamp_ff, nxt_rx_lamp, tx_lamp_ff, nxt_tx_lamp;
   logic rx_start, tx_start;

   function automatic logic [ahl_pkg::CNT_W-1:0] sel_counter(
      input logic [3:0] sel,
      input logic [ahl_pkg::NUM_CNT*ahl_pkg::CNT_W-1:0] flat);
      logic [ahl_pkg::CNT_W-1:0] v;
      v = '0;
      // and-or mux: more than one select bit merges counters
      for (int i = 0; i < ahl_pkg::NUM_CNT; i++) begin
         if (sel[i]) begin
            v = v | flat[i*ahl_pkg::CNT_W +: ahl_pkg::CNT_W];
         end
      end
      return v;
   endfunction

   function automatic logic [LAMP_W-1:0] lamp_next(input logic trig, input logic [LAMP_W-1:0] cnt);
      if (trig) begin
         return LAMP_W'(LAMP_HOLD_CYC);
      end else if (cnt != '0) begin
         return cnt - LAMP_W'(1);
      end
      return cnt;
   endfunction

   ahl_hec_engine u_rx_hec (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .byte_in(rx_byte),
      .byte_valid(rx_valid),
      .cell_start(rx_soc),
      .is_hec_octet(rx_is_hec),
      .hec_value(rx_hec),
      .cell_done(rx_done)
   );

   ahl_hec_engine u_tx_hec (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .byte_in(tx_byte_in),
      .byte_valid(tx_valid_in),
      .cell_start(tx_soc_in),
      .is_hec_octet(tx_is_hec),
      .hec_value(tx_hec),
      .cell_done(tx_done)
   );

   assign rd_start = ub_cs && ub_rd && !rd_prev_ff;
   assign wr_start = ub_cs && ub_wr && !wr_prev_ff;
   assign rx_start = rx_valid && rx_soc;
   assign tx_start = tx_valid_in && tx_soc_in;
   assign hec_err = rx_is_hec && !rx_dis_ff && (rx_byte != rx_hec);
   assign events = {sym_err, tx_done, rx_done, hec_err};
   assign sel_val = sel_counter(sel_ff, {cnt_ff[3], cnt_ff[2], cnt_ff[1], cnt_ff[0]});

   // register bus: read data, write decode, status side effects
   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_oe_n = !(ub_cs && ub_rd);
      nxt_rx_dis = rx_dis_ff;
      nxt_tx_dis = tx_dis_ff;
      nxt_ins = ins_ff;
      nxt_ref_sel = ref_sel_ff;
      nxt_sel = sel_ff;
      nxt_rx_act = rx_act_ff;
      nxt_tx_act = tx_act_ff;
      nxt_int_hec = int_hec_ff;
      if (rd_start) begin
         nxt_rdata = ahl_pkg::BYTE_ZERO;
         unique case (ub_addr)
            ahl_pkg::ADDR_INT_STATUS: begin
               nxt_rdata[ahl_pkg::BIT_INT_HEC] = int_hec_ff;
               nxt_int_hec = 1'b0;
            end
            ahl_pkg::ADDR_DIAG: begin
               nxt_rdata[ahl_pkg::BIT_DIAG_HEC_INS] = ins_ff;
            end
            ahl_pkg::ADDR_LAMP_HEC: begin
               nxt_rdata[ahl_pkg::BIT_RX_HEC_DIS] = rx_dis_ff;
               nxt_rdata[ahl_pkg::BIT_TX_HEC_DIS] = tx_dis_ff;
               nxt_rdata[ahl_pkg::BIT_REF_HI:ahl_pkg::BIT_REF_LO] = ref_sel_ff;
               nxt_rdata[ahl_pkg::BIT_TXQ_EMPTY] = tx_queue_empty;
               nxt_rdata[ahl_pkg::BIT_TX_ACT] = tx_act_ff;
               nxt_rdata[ahl_pkg::BIT_RX_ACT] = rx_act_ff;
               nxt_rx_act = 1'b0;
               nxt_tx_act = 1'b0;
            end
            ahl_pkg::ADDR_CNT_LO: begin
               nxt_rdata = sel_val[7:0];
            end
            ahl_pkg::ADDR_CNT_HI: begin
               nxt_rdata = sel_val[15:8];
            end
            default: begin
               nxt_rdata = ahl_pkg::BYTE_ZERO;
            end
         endcase
      end
      if (wr_start) begin
         unique case (ub_addr)
            ahl_pkg::ADDR_DIAG: begin
               nxt_ins = ub_data_in[ahl_pkg::BIT_DIAG_HEC_INS];
            end
            ahl_pkg::ADDR_LAMP_HEC: begin
               nxt_rx_dis = ub_data_in[ahl_pkg::BIT_RX_HEC_DIS];
               nxt_tx_dis = ub_data_in[ahl_pkg::BIT_TX_HEC_DIS];
               nxt_ref_sel = ub_data_in[ahl_pkg::BIT_REF_HI:ahl_pkg::BIT_REF_LO];
            end
            ahl_pkg::ADDR_CNT_SEL: begin
               nxt_sel = ub_data_in[ahl_pkg::SEL_SYM:ahl_pkg::SEL_HEC];
            end
            default: begin
               nxt_sel = sel_ff;
            end
         endcase
      end
      // a new event beats a clear by read in the same cycle
      if (rx_done) begin
         nxt_rx_act = 1'b1;
      end
      if (tx_done) begin
         nxt_tx_act = 1'b1;
      end
      if (hec_err) begin
         nxt_int_hec = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_prev_ff <= 1'b0;
         wr_prev_ff <= 1'b0;
         rdata_ff <= ahl_pkg::BYTE_ZERO;
         oe_n_ff <= 1'b1;
         rx_dis_ff <= 1'b0;
         tx_dis_ff <= 1'b0;
         ins_ff <= 1'b0;
         ref_sel_ff <= ahl_pkg::REF_SEL_RST;
         sel_ff <= ahl_pkg::SEL_RST;
         rx_act_ff <= 1'b0;
         tx_act_ff <= 1'b0;
         int_hec_ff <= 1'b0;
      end else begin
         rd_prev_ff <= ub_cs && ub_rd;
         wr_prev_ff <= ub_cs && ub_wr;
         rdata_ff <= nxt_rdata;
         oe_n_ff <= nxt_oe_n;
         rx_dis_ff <= nxt_rx_dis;
         tx_dis_ff <= nxt_tx_dis;
         ins_ff <= nxt_ins;
         ref_sel_ff <= nxt_ref_sel;
         sel_ff <= nxt_sel;
         rx_act_ff <= nxt_rx_act;
         tx_act_ff <= nxt_tx_act;
         int_hec_ff <= nxt_int_hec;
      end
   end

   // event counters wrap silently at full scale
   always_comb begin
      for (int i = 0; i < ahl_pkg::NUM_CNT; i++) begin
         nxt_cnt[i] = events[i] ? cnt_ff[i] + ahl_pkg::CNT_W'(1) : cnt_ff[i];
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < ahl_pkg::NUM_CNT; i++) begin
         if (sys_rst) begin
            cnt_ff[i] <= '0;
         end else begin
            cnt_ff[i] <= nxt_cnt[i];
         end
      end
   end

   // transmit byte path, one cycle of latency
   always_comb begin
      nxt_txb = tx_byte_in;
      nxt_txv = tx_valid_in;
      nxt_txs = tx_soc_in;
      if (tx_is_hec) begin
         if (!tx_dis_ff) begin
            nxt_txb = tx_hec;
         end
         if (ins_ff) begin
            nxt_txb = nxt_txb ^ ahl_pkg::HEC_INS_MASK;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         txb_ff <= ahl_pkg::BYTE_ZERO;
         txv_ff <= 1'b0;
         txs_ff <= 1'b0;
      end else begin
         txb_ff <= nxt_txb;
         txv_ff <= nxt_txv;
         txs_ff <= nxt_txs;
      end
   end

   // reference pulse; a new cell start restarts the width count
   always_comb begin
      nxt_ref = 1'b0;
      nxt_ref_cnt = ref_cnt_ff;
      if (rx_start) begin
         nxt_ref = 1'b1;
         nxt_ref_cnt = 3'((4'h1 << ref_sel_ff) - 4'h1);
      end else if (ref_cnt_ff != 3'h0) begin
         nxt_ref = 1'b1;
         nxt_ref_cnt = ref_cnt_ff - 3'h1;
      end
   end

   // lamps: low for a hold window after each cell start, retriggered
   always_comb begin
      nxt_rx_lamp_cnt = lamp_next(rx_start, rx_lamp_cnt_ff);
      nxt_tx_lamp_cnt = lamp_next(tx_start, tx_lamp_cnt_ff);
      nxt_rx_lamp = (nxt_rx_lamp_cnt == '0);
      nxt_tx_lamp = (nxt_tx_lamp_cnt == '0);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ref_ff <= 1'b0;
         ref_cnt_ff <= 3'h0;
         rx_lamp_cnt_ff <= '0;
         tx_lamp_cnt_ff <= '0;
         rx_lamp_ff <= 1'b1;
         tx_lamp_ff <= 1'b1;
      end else begin
         ref_ff <= nxt_ref;
         ref_cnt_ff <= nxt_ref_cnt;
         rx_lamp_cnt_ff <= nxt_rx_lamp_cnt;
         tx_lamp_cnt_ff <= nxt_tx_lamp_cnt;
         rx_lamp_ff <= nxt_rx_lamp;
         tx_lamp_ff <= nxt_tx_lamp;
      end
   end

   assign ub_data_out = rdata_ff;
   assign ub_data_oe_n = oe_n_ff;
   assign tx_byte_out = txb_ff;
   assign tx_valid_out = txv_ff;
   assign tx_soc_out = txs_ff;
   assign rx_cell_ref_pulse = ref_ff;
   assign rx_activity_lamp = rx_lamp_ff;
   assign tx_activity_lamp = tx_lamp_ff;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_read_of(logic [7:0] a);
      rd_start && ub_addr == a;
   endsequence

   a_rx_check_off: assert property (rx_is_hec && rx_dis_ff |=> cnt_ff[0] == $past(cnt_ff[0]))
      else $error("header error counted while checking disabled");
   a_tx_hec_replace: assert property (tx_is_hec && !tx_dis_ff && !ins_ff |=> tx_byte_out == $past(tx_hec))
      else $error("fifth octet not replaced by checksum");
   a_tx_hec_pass: assert property (tx_is_hec && tx_dis_ff && !ins_ff |=> tx_byte_out == $past(tx_byte_in))
      else $error("fifth octet altered while generation disabled");
   a_tx_hec_insert: assert property (tx_is_hec && !tx_dis_ff && ins_ff |=> tx_byte_out == ($past(tx_hec) ^ 8'h01))
      else $error("inserted header error not bit 0 flip");
   a_ref_width_max: assert property ($rose(rx_cell_ref_pulse) && ref_sel_ff == ahl_pkg::REF_SEL_MAX
      && $past(ref_sel_ff) == ahl_pkg::REF_SEL_MAX |-> rx_cell_ref_pulse [*8])
      else $error("reference pulse shorter than eight cycles");
   a_ref_width_min: assert property ($rose(rx_cell_ref_pulse) && $past(ref_sel_ff) == ahl_pkg::REF_SEL_RST
      && !rx_start |=> !rx_cell_ref_pulse)
      else $error("reference pulse longer than one cycle");
   a_txq_status: assert property (s_read_of(ahl_pkg::ADDR_LAMP_HEC) |=> ub_data_out[2] == $past(tx_queue_empty))
      else $error("queue empty bit wrong");
   a_tx_act_set: assert property (tx_done |=> tx_act_ff)
      else $error("transmit activity not set");
   a_rx_act_set: assert property (rx_done |=> rx_act_ff)
      else $error("receive activity not set");
   a_lo_byte_read: assert property (s_read_of(ahl_pkg::ADDR_CNT_LO) && sel_ff == 4'h2
      |=> ub_data_out == $past(cnt_ff[1][7:0]))
      else $error("low byte of selected counter wrong");
   a_hi_byte_read: assert property (s_read_of(ahl_pkg::ADDR_CNT_HI) && sel_ff == 4'h8
      |=> ub_data_out == $past(cnt_ff[3][15:8]))
      else $error("high byte of selected counter wrong");
   a_hec_flag_set: assert property (hec_err |=> int_hec_ff [*1] ##0 cnt_ff[0] == $past(cnt_ff[0]) + 16'h0001)
      else $error("header error not flagged or counted");
   a_rx_lamp_on: assert property (rx_start |=> !rx_activity_lamp)
      else $error("receive lamp not low on activity");
   a_tx_lamp_on: assert property (tx_start |=> !tx_activity_lamp)
      else $error("transmit lamp not low on activity");
endmodule
`default_nettype wire

// ===== verilog/ahl_pkg.sv
// constants of the lamp, header-check and counter register bank
// Function
// - receive header check over four octets compared with fifth while bit 6 is clear
// - transmit header checksum replaces fifth octet unless bit 5 is set
// - bits 4:3 set reference pulse width: 1, 2, 4 or 8 cycles, reset 00
// - read-only bit 2 reads 1 when transmit queue is empty, reset 1
// - read-only bit 1 reads 1 once a cell has been transmitted, reset 0
// - read-only bit 0 reads 1 once a cell has been received, reset 0
// - offset 0x04 returns low byte of selected counter, 0x00 after reset
// - offset 0x05 returns high byte of selected 16-bit counter
// - write-only offset 0x06 bits 3..0 select symbol, tx, rx, header-error counter
// - receive lamp driven both ways: low for a hold window after each cell start, high otherwise
// - failed receive header check sets sticky interrupt status bit 5
// - diagnostic insert bit inverts bit 0 of transmitted header checksum
package ahl_pkg;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h01;
   localparam logic [7:0] ADDR_DIAG = 8'h02;
   localparam logic [7:0] ADDR_LAMP_HEC = 8'h03;
   localparam logic [7:0] ADDR_CNT_LO = 8'h04;
   localparam logic [7:0] ADDR_CNT_HI = 8'h05;
   localparam logic [7:0] ADDR_CNT_SEL = 8'h06;

   localparam int BIT_RX_HEC_DIS = 6;
   localparam int BIT_TX_HEC_DIS = 5;
   localparam int BIT_REF_HI = 4;
   localparam int BIT_REF_LO = 3;
   localparam int BIT_TXQ_EMPTY = 2;
   localparam int BIT_TX_ACT = 1;
   localparam int BIT_RX_ACT = 0;
   localparam int BIT_INT_HEC = 5;
   localparam int BIT_DIAG_HEC_INS = 2;

   localparam int SEL_HEC = 0;
   localparam int SEL_RXC = 1;
   localparam int SEL_TXC = 2;
   localparam int SEL_SYM = 3;
   localparam int NUM_CNT = 4;
   localparam int CNT_W = 16;

   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] REF_SEL_RST = 2'h0;
   localparam logic [1:0] REF_SEL_MAX = 2'h3;
   localparam logic [3:0] SEL_RST = 4'h0;
   localparam logic [7:0] HEC_INS_MASK = 8'h01;

   localparam int CELL_OCTETS = 53;
   localparam int HDR_OCTETS = 4;
   localparam logic [7:0] HEC_POLY = 8'h07;
   localparam logic [7:0] HEC_COSET = 8'h00;

   localparam int CLK_MHZ = 20;
   localparam int LAMP_HOLD_US = 1000;
   localparam int LAMP_HOLD_CYC = LAMP_HOLD_US * CLK_MHZ;
endpackage

// ===== verilog/ahl_hec_engine.sv
// octet tracker and header checksum of one cell byte stream
`timescale 1ns/1ns
`default_nettype none
module ahl_hec_engine (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] byte_in,
   input wire logic byte_valid,
   input wire logic cell_start,
   output logic is_hec_octet,
   output logic [7:0] hec_value,
   output logic cell_done
);
   logic [5:0] idx_ff, nxt_idx;
   logic [7:0] crc_ff, nxt_crc;

   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ ahl_pkg::HEC_POLY) : (c << 1);
      end
      return c;
   endfunction

   always_comb begin
      nxt_idx = idx_ff;
      nxt_crc = crc_ff;
      if (byte_valid && cell_start) begin
         nxt_idx = 6'd1;
         nxt_crc = crc_step(ahl_pkg::BYTE_ZERO, byte_in);
      end else if (byte_valid && idx_ff < 6'(ahl_pkg::CELL_OCTETS)) begin
         nxt_idx = idx_ff + 6'd1;
         if (idx_ff < 6'(ahl_pkg::HDR_OCTETS)) begin
            nxt_crc = crc_step(crc_ff, byte_in);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         idx_ff <= 6'(ahl_pkg::CELL_OCTETS);
         crc_ff <= ahl_pkg::BYTE_ZERO;
      end else begin
         idx_ff <= nxt_idx;
         crc_ff <= nxt_crc;
      end
   end

   assign is_hec_octet = byte_valid && !cell_start && (idx_ff == 6'(ahl_pkg::HDR_OCTETS));
   assign hec_value = crc_ff ^ ahl_pkg::HEC_COSET;
   assign cell_done = byte_valid && !cell_start && (idx_ff == 6'(ahl_pkg::CELL_OCTETS - 1));
endmodule
`default_nettype wire

// ===== dv/ahl_host_model.sv
// host processor model issuing utility bus register cycles
`timescale 1ns/1ns
`default_nettype none
module ahl_host_model (
   input wire logic sys_clk,
   output logic ub_cs,
   output logic ub_rd,
   output logic ub_wr,
   output logic [7:0] ub_addr,
   output logic [7:0] ub_data_in,
   input wire logic [7:0] ub_data_out
);
   initial begin
      ub_cs = 1'b0;
      ub_rd = 1'b0;
      ub_wr = 1'b0;
      ub_addr = 8'h00;
      ub_data_in = 8'h00;
   end

   // no ready line: strobe held over the taking edge and the answer edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      ub_cs <= 1'b1;
      ub_rd <= !w;
      ub_wr <= w;
      ub_addr <= a;
      ub_data_in <= d;
      @(posedge sys_clk);
      @(posedge sys_clk);
      @(posedge sys_clk);
      q = ub_data_out;
      ub_cs <= 1'b0;
      ub_rd <= 1'b0;
      ub_wr <= 1'b0;
      // released lines show a changed value, never the stale one
      ub_addr <= ~a;
      ub_data_in <= ~d;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench of the lamp, header-check and counter register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; $display("[FAIL] %0t value mismatch got %0h exp %0h", $time, got, exp); end end
module tb_top;
   logic sys_clk, sys_rst, ub_cs, ub_rd, ub_wr, ub_data_oe_n;
   logic [7:0] ub_addr, ub_data_in, ub_data_out, rx_byte, tx_byte_in, tx_byte_out, tx_hec, q;
   logic rx_valid, rx_soc, sym_err, tx_valid_in, tx_soc_in, tx_valid_out, tx_soc_out, tx_queue_empty;
   logic rx_cell_ref_pulse, rx_activity_lamp, tx_activity_lamp, rx_lamp_seen, tx_lamp_seen;
   logic [15:0] hec_exp, rxc_exp, txc_exp;
   logic [31:0] h;
   logic [7:0] g, e;
   int err_total, checks, ref_cnt, tx_idx, n;
   logic bad, dis, oe_exp;

   ahl_regs #(.LAMP_HOLD_CYC(8)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ub_cs(ub_cs), .ub_rd(ub_rd),
      .ub_wr(ub_wr), .ub_addr(ub_addr), .ub_data_in(ub_data_in), .ub_data_out(ub_data_out),
      .ub_data_oe_n(ub_data_oe_n), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_soc(rx_soc), .sym_err(sym_err),
      .tx_byte_in(tx_byte_in), .tx_valid_in(tx_valid_in), .tx_soc_in(tx_soc_in), .tx_byte_out(tx_byte_out),
      .tx_valid_out(tx_valid_out), .tx_soc_out(tx_soc_out), .tx_queue_empty(tx_queue_empty),
      .rx_cell_ref_pulse(rx_cell_ref_pulse), .rx_activity_lamp(rx_activity_lamp),
      .tx_activity_lamp(tx_activity_lamp));
   ahl_host_model host (.sys_clk(sys_clk), .ub_cs(ub_cs), .ub_rd(ub_rd), .ub_wr(ub_wr), .ub_addr(ub_addr),
      .ub_data_in(ub_data_in), .ub_data_out(ub_data_out));

   always #25 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      if (rx_cell_ref_pulse === 1'b1) ref_cnt++;
      if (rx_activity_lamp === 1'b0) rx_lamp_seen = 1'b1;
      if (tx_activity_lamp === 1'b0) tx_lamp_seen = 1'b1;
      // data drive enable follows the read strobe one cycle late
      if (!sys_rst) `CHK(ub_data_oe_n, oe_exp);
      oe_exp = !(ub_cs && ub_rd);
      if (tx_valid_out === 1'b1) begin
         tx_idx = (tx_soc_out === 1'b1) ? 0 : tx_idx + 1;
         if (tx_idx == 4) tx_hec = tx_byte_out;
      end
   end

   // msb-first crc over the four header octets, zero coset
   function automatic logic [7:0] crc8(input logic [31:0] hd);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ hd[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      host.acc(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a);
      host.acc(1'b0, a, 8'h00, q);
   endtask

   task automatic send_cell(input logic tx, input logic [31:0] hd, input logic [7:0] hec);
      logic [7:0] b;
      for (int i = 0; i < 53; i++) begin
         @(posedge sys_clk);
         b = (i < 4) ? hd[31-8*i -: 8] : ((i == 4) ? hec : 8'($urandom));
         if (tx) begin
            tx_valid_in <= 1'b1;
            tx_soc_in <= (i == 0);
            tx_byte_in <= b;
         end else begin
            rx_valid <= 1'b1;
            rx_soc <= (i == 0);
            rx_byte <= b;
         end
      end
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_soc <= 1'b0;
      tx_valid_in <= 1'b0;
      tx_soc_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic chk_cnt(input int s, input logic [15:0] x);
      logic [7:0] lo;
      wr(8'h06, 8'h01 << s);
      rd(8'h04);
      lo = q;
      rd(8'h05);
      `CHK({q, lo}, x);
   endtask

   task automatic conclude();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      #(50 * 30000);
      err_total++;
      conclude();
   end

   initial begin
      {sys_clk, rx_valid, rx_soc, sym_err, tx_valid_in, tx_soc_in} = 6'h00;
      {rx_byte, tx_byte_in} = 16'h0000;
      {err_total, checks, ref_cnt, tx_idx} = {4{32'h0}};
      {hec_exp, rxc_exp, txc_exp} = 48'h0;
      tx_queue_empty = 1'b1;
      oe_exp = 1'b1;
      sys_rst = 1'b1;
      void'($urandom(32'h567E));
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h03);
      `CHK(q, 8'h04);
      rd(8'h04);
      `CHK(q, 8'h00);
      rd(8'h05);
      `CHK(q, 8'h00);
      rd(8'h07);
      `CHK(q, 8'h00);
      `CHK({rx_activity_lamp, tx_activity_lamp}, 2'h3);
      for (int w = 0; w < 4; w++) begin
         wr(8'h03, 8'(w << 3));
         ref_cnt = 0;
         rx_lamp_seen = 1'b0;
         h = $urandom;
         send_cell(1'b0, h, crc8(h));
         rxc_exp++;
         `CHK(ref_cnt, 1 << w);
         `CHK({rx_lamp_seen, rx_activity_lamp}, 2'h3);
         rd(8'h03);
         `CHK(q, 8'(w << 3) | 8'h05);
      end
      // first cell is always a bad header while checking is on
      for (int i = 0; i < 12; i++) begin
         dis = (i >= 8);
         bad = (i == 0) ? 1'b1 : 1'($urandom);
         wr(8'h03, {1'b0, dis, 6'h00});
         h = $urandom;
         send_cell(1'b0, h, crc8(h) ^ (bad ? 8'($urandom_range(1, 255)) : 8'h00));
         rxc_exp++;
         if (bad && !dis) hec_exp++;
         rd(8'h01);
         `CHK(q[5], bad && !dis);
      end
      chk_cnt(0, hec_exp);
      chk_cnt(1, rxc_exp);
      for (int i = 0; i < 9; i++) begin
         wr(8'h03, (i % 3 == 1) ? 8'h20 : 8'h00);
         wr(8'h02, (i % 3 == 2) ? 8'h04 : 8'h00);
         h = $urandom;
         g = 8'($urandom);
         tx_lamp_seen = 1'b0;
         send_cell(1'b1, h, g);
         txc_exp++;
         e = (i % 3 == 1) ? g : (crc8(h) ^ ((i % 3 == 2) ? 8'h01 : 8'h00));
         `CHK(tx_hec, e);
         `CHK(tx_lamp_seen, 1'b1);
         `CHK(tx_idx, 52);
      end
      @(posedge sys_clk);
      tx_queue_empty <= 1'b0;
      rd(8'h03);
      `CHK(q, 8'h03);
      rd(8'h03);
      `CHK(q, 8'h00);
      wr(8'h02, 8'h00);
      chk_cnt(2, txc_exp);
      n = $urandom_range(3, 20);
      repeat (n) begin
         @(posedge sys_clk);
         sym_err <= 1'b1;
         @(posedge sys_clk);
         sym_err <= 1'b0;
      end
      chk_cnt(3, 16'(n));
      conclude();
   end
endmodule
`default_nettype wire
